// file: hw/error_history.v
// sixteen-entry timestamped error history ring
`timescale 1ns/1ps
`include "scan_supervisor_defs.vh"
module error_history (
    input  wire                    sys_clk,
    input  wire                    sys_rst,
    input  wire                    log_stb,
    input  wire [47:0]             log_time,
    input  wire [15:0]             log_code,
    input  wire                    clear,
    input  wire [`HIST_WIDX_W-1:0] rd_word,
    output reg  [15:0]             rd_data,
    output reg  [`HIST_IDX_W-1:0]  head
);
    reg [63:0] entry [0:`HIST_DEPTH-1];
    integer i;

    // oldest entry overwritten, so only the 16 newest remain
    always @(posedge sys_clk) begin
        if (sys_rst || clear) begin
            head <= {`HIST_IDX_W{1'b0}};
            for (i = 0; i < `HIST_DEPTH; i = i + 1)
                entry[i] <= 64'h0;
        end else if (log_stb) begin
            entry[head - 1'b1] <= {log_time, log_code};
            head <= head - 1'b1;
        end
    end

    // word 0 is newest entry; entry n starts at word 4n
    // read is combinational so the bus can latch it in phase 0
    wire [`HIST_IDX_W-1:0] slot = head + rd_word[`HIST_WIDX_W-1:2];
    wire [63:0]            e    = entry[slot];
    always @* begin
        case (rd_word[1:0])
            2'd0:    rd_data = e[63:48];
            2'd1:    rd_data = e[47:32];
            2'd2:    rd_data = e[31:16];
            default: rd_data = e[15:0];
        endcase
    end
endmodule // error_history

// file: hw/scan_supervisor.v
// scan watchdog, diagnosis stop, force override and io image refresh
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "scan_supervisor_defs.vh"
module scan_supervisor (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        power_on,
    input  wire        flash_boot_switch,
    input  wire        battery_low,
    input  wire        diag_fault,
    input  wire        scan_end,
    input  wire        scan_start,
    input  wire        scan_timer_restart_instr,
    input  wire        program_download,
    input  wire        backup_lost,
    input  wire        input_refresh,
    input  wire        output_refresh,
    input  wire        direct_refresh_instr,
    input  wire        direct_is_output,
    input  wire [8:0]  direct_point,
    input  wire [63:0] main_in_pins,
    input  wire [15:0] exp1_in_pins,
    input  wire [15:0] exp2_in_pins,
    input  wire [63:0] out_image_main,
    input  wire [15:0] out_image_exp1,
    input  wire [15:0] out_image_exp2,
    input  wire [47:0] rtc_time,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [63:0] in_image_main,
    output reg  [15:0] in_image_exp1,
    output reg  [15:0] in_image_exp2,
    output reg  [63:0] main_out_pins,
    output reg  [15:0] exp1_out_pins,
    output reg  [15:0] exp2_out_pins,
    output reg         program_run,
    output reg         run_indicator,
    output reg         fault_indicator,
    output reg         battery_low_indicator,
    output reg         flash_operation
);
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN  = 2'd1;
    localparam ST_STOP = 2'd2;

    reg [1:0]          state;
    reg [`WDT_W-1:0]   wdt_ms;
    reg [`WDT_W-1:0]   wdt_cnt;
    reg                wdt_expired;
    reg                diag_stop;
    reg [23:0]         blink_cnt;
    reg                blink;
    reg                force_all;
    reg [15:0]         force_ena [0:`FORCE_WORDS-1];
    reg [15:0]         force_val [0:`FORCE_WORDS-1];
    reg                log_stb;
    reg [15:0]         log_code;
    reg                hist_clear;
    reg                bus_phase;
    wire [15:0]        hist_data;
    wire [`HIST_IDX_W-1:0] hist_head;
    integer            k;

    // flat 512-point force vectors, indexed by point number
    reg [511:0] fena_flat;
    reg [511:0] fval_flat;
    always @* begin
        for (k = 0; k < `FORCE_WORDS; k = k + 1) begin
            fena_flat[k*16 +: 16] = force_all ? force_ena[k] : 16'h0;
            fval_flat[k*16 +: 16] = force_val[k];
        end
    end

    // apply force to one group of points; unfitted points too
    function [63:0] apply_force;
        input [63:0] raw;
        input [63:0] ena;
        input [63:0] val;
        begin
            apply_force = (raw & ~ena) | (val & ena);
        end
    endfunction

    function [`WDT_W-1:0] ms_to_cyc;
        input [`WDT_W-1:0] ms;
        begin
            ms_to_cyc = ms * `WDT_MS_CYC;
        end
    endfunction

    wire [63:0] in_main_f = apply_force(main_in_pins,
        fena_flat[`MAIN_IN_BASE +: 64], fval_flat[`MAIN_IN_BASE +: 64]);
    wire [63:0] in_e1_f = apply_force({48'h0, exp1_in_pins},
        {48'h0, fena_flat[`EXP1_IN_BASE +: 16]},
        {48'h0, fval_flat[`EXP1_IN_BASE +: 16]});
    wire [63:0] in_e2_f = apply_force({48'h0, exp2_in_pins},
        {48'h0, fena_flat[`EXP2_IN_BASE +: 16]},
        {48'h0, fval_flat[`EXP2_IN_BASE +: 16]});
    wire [63:0] out_main_f = apply_force(out_image_main,
        fena_flat[`MAIN_OUT_BASE +: 64], fval_flat[`MAIN_OUT_BASE +: 64]);
    wire [63:0] out_e1_f = apply_force({48'h0, out_image_exp1},
        {48'h0, fena_flat[`EXP1_OUT_BASE +: 16]},
        {48'h0, fval_flat[`EXP1_OUT_BASE +: 16]});
    wire [63:0] out_e2_f = apply_force({48'h0, out_image_exp2},
        {48'h0, fena_flat[`EXP2_OUT_BASE +: 16]},
        {48'h0, fval_flat[`EXP2_OUT_BASE +: 16]});

    wire halted = wdt_expired | diag_stop;
    wire force_clear = program_download | backup_lost |
                       (power_on & flash_boot_switch);

    // boot mode is caught on the power-on pulse, not at reset
    always @(posedge sys_clk) begin
        if (sys_rst)
            flash_operation <= 1'b0;
        else if (power_on)
            flash_operation <= flash_boot_switch;
    end

    // scan state: running until watchdog or diagnosis stop
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state       <= ST_IDLE;
            wdt_expired <= 1'b0;
            diag_stop   <= 1'b0;
            wdt_cnt     <= {`WDT_W{1'b0}};
            log_stb     <= 1'b0;
            log_code    <= 16'h0;
        end else begin
            log_stb <= 1'b0;
            case (state)
                ST_IDLE: begin
                    wdt_cnt <= {`WDT_W{1'b0}};
                    if (diag_fault) begin
                        diag_stop <= 1'b1;
                        state     <= ST_STOP;
                        log_stb   <= 1'b1;
                        log_code  <= `ERR_DIAG;
                    end else if (scan_start || power_on) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (diag_fault) begin
                        diag_stop <= 1'b1;
                        state     <= ST_STOP;
                        log_stb   <= 1'b1;
                        log_code  <= `ERR_DIAG;
                    end else if (scan_end || scan_timer_restart_instr) begin
                        wdt_cnt <= {`WDT_W{1'b0}};
                    end else if (wdt_cnt >= ms_to_cyc(wdt_ms) - 1'b1) begin
                        wdt_expired <= 1'b1;
                        state       <= ST_STOP;
                        log_stb     <= 1'b1;
                        log_code    <= `ERR_WDT;
                    end else begin
                        wdt_cnt <= wdt_cnt + 1'b1;
                    end
                end
                ST_STOP: begin
                    // only a power-on or sys_rst clears a halt
                    if (power_on) begin
                        wdt_expired <= 1'b0;
                        diag_stop   <= 1'b0;
                        state       <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // indicators
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            blink_cnt             <= 24'h0;
            blink                 <= 1'b0;
            program_run           <= 1'b0;
            run_indicator         <= 1'b0;
            fault_indicator       <= 1'b0;
            battery_low_indicator <= 1'b0;
        end else begin
            if (blink_cnt == `FLASH_HZ_DIV) begin
                blink_cnt <= 24'h0;
                blink     <= ~blink;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
            program_run           <= (state == ST_RUN) & ~diag_fault;
            run_indicator         <= (state == ST_RUN) & ~halted;
            fault_indicator       <= wdt_expired ? blink : diag_stop;
            battery_low_indicator <= battery_low;
        end
    end

    // io refresh; halt drives all outputs off
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            in_image_main <= 64'h0;
            in_image_exp1 <= 16'h0;
            in_image_exp2 <= 16'h0;
            main_out_pins <= 64'h0;
            exp1_out_pins <= 16'h0;
            exp2_out_pins <= 16'h0;
        end else begin
            if (input_refresh) begin
                in_image_main <= in_main_f;
                in_image_exp1 <= in_e1_f[15:0];
                in_image_exp2 <= in_e2_f[15:0];
            end else if (direct_refresh_instr && !direct_is_output) begin
                if (direct_point < `MAIN_IN_BASE + `MAIN_PTS)
                    in_image_main[direct_point[5:0]] <=
                        in_main_f[direct_point[5:0]];
                else if (direct_point[8:4] == `EXP1_IN_BASE >> 4)
                    in_image_exp1[direct_point[3:0]] <=
                        in_e1_f[direct_point[3:0]];
                else if (direct_point[8:4] == `EXP2_IN_BASE >> 4)
                    in_image_exp2[direct_point[3:0]] <=
                        in_e2_f[direct_point[3:0]];
            end
            if (halted) begin
                main_out_pins <= 64'h0;
                exp1_out_pins <= 16'h0;
                exp2_out_pins <= 16'h0;
            end else if (output_refresh) begin
                main_out_pins <= out_main_f;
                exp1_out_pins <= out_e1_f[15:0];
                exp2_out_pins <= out_e2_f[15:0];
            end else if (direct_refresh_instr && direct_is_output) begin
                if (direct_point[8:6] == `MAIN_OUT_BASE >> 6)
                    main_out_pins[direct_point[5:0]] <=
                        out_main_f[direct_point[5:0]];
                else if (direct_point[8:4] == `EXP1_OUT_BASE >> 4)
                    exp1_out_pins[direct_point[3:0]] <=
                        out_e1_f[direct_point[3:0]];
                else if (direct_point[8:4] == `EXP2_OUT_BASE >> 4)
                    exp2_out_pins[direct_point[3:0]] <=
                        out_e2_f[direct_point[3:0]];
            end
        end
    end

    // bus writes; force data not reset by sys_rst so it persists
    wire bus_wr = avs_write & bus_phase;
    always @(posedge sys_clk) begin
        if (force_clear) begin
            force_all <= 1'b0;
            for (k = 0; k < `FORCE_WORDS; k = k + 1) begin
                force_ena[k] <= 16'h0;
                force_val[k] <= 16'h0;
            end
        end else if (bus_wr) begin
            if (avs_address == `A_CTRL)
                force_all <= avs_writedata[`CTRL_FENA_BIT];
            if (avs_address[7:5] == `A_FENA_BASE >> 5)
                force_ena[avs_address[4:0]] <= avs_writedata[15:0];
            if (avs_address[7:5] == `A_FVAL_BASE >> 5)
                force_val[avs_address[4:0]] <= avs_writedata[15:0];
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst)
            wdt_ms <= `WDT_DEF_MS;
        else if (bus_wr && avs_address == `A_WDT_MS &&
                 avs_writedata != 32'h0)
            wdt_ms <= avs_writedata;
    end

    always @(posedge sys_clk) begin
        if (sys_rst)
            hist_clear <= 1'b0;
        else
            hist_clear <= bus_wr && avs_address == `A_HIST_HEAD;
    end

    // two-cycle access: phase 0 fetches, phase 1 answers
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            bus_phase       <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if ((avs_read || avs_write) && !bus_phase) begin
            bus_phase       <= 1'b1;
            avs_waitrequest <= 1'b0;
        end else begin
            bus_phase       <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        if (!sys_rst && avs_read && !bus_phase) begin
            if (avs_address == `A_CTRL)
                avs_readdata <= {31'h0, force_all};
            else if (avs_address == `A_STATUS)
                avs_readdata <= {26'h0, force_all, flash_operation,
                                 battery_low, diag_stop, wdt_expired,
                                 state == ST_RUN};
            else if (avs_address == `A_WDT_MS)
                avs_readdata <= wdt_ms;
            else if (avs_address == `A_HIST_HEAD)
                avs_readdata <= {28'h0, hist_head};
            else if (avs_address[7:5] == `A_FENA_BASE >> 5)
                avs_readdata <= {16'h0, force_ena[avs_address[4:0]]};
            else if (avs_address[7:5] == `A_FVAL_BASE >> 5)
                avs_readdata <= {16'h0, force_val[avs_address[4:0]]};
            else if (avs_address[7:6] == `A_HIST_BASE >> 6)
                avs_readdata <= {16'h0, hist_data};
            else
                avs_readdata <= 32'h0;
        end
    end

    // history read is combinational, latched with the other reads
    error_history u_hist (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .log_stb  (log_stb),
        .log_time (rtc_time),
        .log_code (log_code),
        .clear    (hist_clear),
        .rd_word  (avs_address[5:0]),
        .rd_data  (hist_data),
        .head     (hist_head)
    );
endmodule // scan_supervisor

// file: hw/scan_supervisor_defs.vh
// constants for the scan supervisor and force/io image block
`ifndef SCAN_SUPERVISOR_DEFS_VH
`define SCAN_SUPERVISOR_DEFS_VH

`define CLK_HZ          50000000
`define WDT_DEF_MS      200
`define WDT_MS_CYC      (`CLK_HZ / 1000)
`define WDT_W           32
`define FLASH_HZ_DIV    24'h2faf08

`define FORCE_WORDS     32
`define FORCE_IDX_W     5
`define HIST_DEPTH      16
`define HIST_IDX_W      4
`define HIST_WORDS      64
`define HIST_WIDX_W     6

`define PT_IDX_W        9
`define MAIN_IN_BASE    9'h000
`define MAIN_OUT_BASE   9'h040
`define EXP1_IN_BASE    9'h080
`define EXP1_OUT_BASE   9'h090
`define EXP2_IN_BASE    9'h100
`define EXP2_OUT_BASE   9'h110
`define MAIN_PTS        64
`define EXP_PTS         16

`define ERR_WDT         16'h0001
`define ERR_DIAG        16'h0002

`define ADDR_W          8
`define A_CTRL          8'h00
`define A_STATUS        8'h01
`define A_WDT_MS        8'h02
`define A_HIST_HEAD     8'h03
`define A_FENA_BASE     8'h40
`define A_FVAL_BASE     8'h60
`define A_HIST_BASE     8'h80

`define CTRL_FENA_BIT   0
`define ST_RUN_BIT      0
`define ST_WDT_BIT      1
`define ST_DIAG_BIT     2
`define ST_BAT_BIT      3
`define ST_FLASH_BIT    4
`define ST_FENA_BIT     5
`define ST_W            6

`endif

// file: verification/io_modules.sv
// digital input modules driving the input terminals
`timescale 1ns/1ps
module io_modules (
    input  wire        sys_clk,
    input  wire [63:0] main_lvl,
    input  wire [15:0] exp1_lvl,
    input  wire [15:0] exp2_lvl,
    output reg  [63:0] main_in_pins,
    output reg  [15:0] exp1_in_pins,
    output reg  [15:0] exp2_in_pins
);
    // one clock of terminal filter, so a level never lands on a refresh
    always @(posedge sys_clk) begin
        main_in_pins <= main_lvl;
        exp1_in_pins <= exp1_lvl;
        exp2_in_pins <= exp2_lvl;
    end
endmodule // io_modules

// file: verification/scan_supervisor_properties.sv
// port assertions for the scan supervisor
`timescale 1ns/1ps
`include "scan_supervisor_defs.vh"
module scan_supervisor_properties (
    input wire        sys_clk,
    input wire        sys_rst,
    input wire        power_on,
    input wire        flash_boot_switch,
    input wire        battery_low,
    input wire        diag_fault,
    input wire        scan_end,
    input wire        scan_start,
    input wire        scan_timer_restart_instr,
    input wire        direct_refresh_instr,
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire [63:0] main_out_pins,
    input wire [15:0] exp1_out_pins,
    input wire [15:0] exp2_out_pins,
    input wire        program_run,
    input wire        run_indicator,
    input wire        fault_indicator,
    input wire        battery_low_indicator,
    input wire        flash_operation
);
    reg  [31:0] wdt_ms;
    reg  [39:0] wdt_cnt;
    wire [39:0] wdt_limit = wdt_ms * `WDT_MS_CYC;
    // mirror of the timeout word; a zero write is refused
    always @(posedge sys_clk) begin
        if (sys_rst)
            wdt_ms <= `WDT_DEF_MS;
        else if (avs_write && !avs_waitrequest && avs_address == `A_WDT_MS
                 && avs_writedata != 32'h0)
            wdt_ms <= avs_writedata;
    end
    // cycles since the last restart; margins of 3 absorb start skew
    always @(posedge sys_clk) begin
        if (sys_rst || !program_run || scan_end || scan_start
            || scan_timer_restart_instr)
            wdt_cnt <= 40'h0;
        else
            wdt_cnt <= wdt_cnt + 40'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    bat_rise_a: assert property ($rose(battery_low) |->
        ##[1:2] battery_low_indicator) else $error("battery lamp late");
    bat_fall_a: assert property ($fell(battery_low) |->
        ##[1:2] !battery_low_indicator) else $error("battery lamp stuck");
    diag_halt_a: assert property (diag_fault |-> ##[1:2] !program_run)
        else $error("fault did not halt");
    wdt_early_a: assert property (program_run && !diag_fault
        && wdt_cnt < wdt_limit - 40'd3 |=> program_run)
        else $error("watchdog fired early");
    wdt_late_a: assert property (wdt_cnt == wdt_limit + 40'd3
        |-> !program_run) else $error("watchdog never fired");
    halt_dark_a: assert property ($fell(program_run) && !diag_fault
        |-> ##[0:2] (main_out_pins == 64'h0 && exp1_out_pins == 16'h0
        && exp2_out_pins == 16'h0)) else $error("outputs left on");
    lamp_pair_a: assert property (fault_indicator |-> !run_indicator)
        else $error("run lamp lit with fault");
    bus_answer_a: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    bus_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    flash_flag_a: assert property (power_on |=>
        flash_operation == $past(flash_boot_switch))
        else $error("flash flag wrong");
    cover property ($fell(program_run) && !diag_fault);
    cover property (power_on && flash_boot_switch);
    cover property (direct_refresh_instr);
endmodule // scan_supervisor_properties

bind scan_supervisor scan_supervisor_properties
    i_scan_supervisor_properties (.*);

// file: verification/scan_supervisor_test.sv
// self-checking bench for the scan supervisor
`timescale 1ns/1ps
`include "scan_supervisor_defs.vh"
module scan_supervisor_test;
    logic        sys_clk = 0, sys_rst = 1, power_on = 0;
    logic        flash_boot_switch = 0, battery_low = 0, diag_fault = 0;
    logic        scan_end = 0, scan_start = 0, scan_timer_restart_instr = 0;
    logic        program_download = 0, backup_lost = 0;
    logic        input_refresh = 0, output_refresh = 0;
    logic        direct_refresh_instr = 0, direct_is_output = 0;
    logic [8:0]  direct_point = 9'h000;
    logic [63:0] main_lvl = 64'h0, out_image_main = 64'h0;
    logic [15:0] exp1_lvl = 16'h0, exp2_lvl = 16'h0;
    logic [15:0] out_image_exp1 = 16'h0, out_image_exp2 = 16'h0;
    logic [47:0] rtc_time = 48'h2405_1712_3045;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 32'h0, rd;
    wire  [31:0] avs_readdata;
    wire  [63:0] main_in_pins, in_image_main, main_out_pins;
    wire  [15:0] exp1_in_pins, exp2_in_pins, in_image_exp1, in_image_exp2;
    wire  [15:0] exp1_out_pins, exp2_out_pins;
    wire         avs_waitrequest, program_run, run_indicator;
    wire         fault_indicator, battery_low_indicator, flash_operation;
    integer      mismatches = 0, n_compared = 0, n;

    scan_supervisor i_scan_supervisor (.*);
    io_modules i_io_modules (.*);

    always #10 sys_clk = ~sys_clk;

    task tick(input integer c);
        repeat (c) @(posedge sys_clk);
    endtask
    task check(input string what, input logic [63:0] exp,
               input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        if (w) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 50) mismatches++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd_chk(input string what, input logic [7:0] a,
                input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(what, {32'h0, e}, {32'h0, rd});
    endtask
    task refresh;
        tick(2);
        input_refresh <= 1;
        output_refresh <= 1;
        tick(1);
        input_refresh <= 0;
        output_refresh <= 0;
        tick(3);
    endtask
    task boot(input logic flash);
        flash_boot_switch <= flash;
        power_on <= 1;
        tick(1);
        power_on <= 0;
        scan_start <= 1;
        tick(1);
        scan_start <= 0;
        tick(2);
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // cut a hang well past the longest watchdog run
    initial begin
        repeat (110000) @(posedge sys_clk);
        mismatches++;
        test_done;
    end

    initial begin
        tick(16);
        sys_rst <= 0;
        tick(2);
        // force store has no reset; clear it as a download would
        program_download <= 1;
        tick(1);
        program_download <= 0;
        rd_chk("wdt ms", `A_WDT_MS, `WDT_DEF_MS);
        rd_chk("unmapped", 8'hc0, 32'h0);
        battery_low <= 1;
        tick(3);
        check("bat lamp", 1, battery_low_indicator);
        battery_low <= 0;
        boot(0);
        check("flash flag", 0, flash_operation);
        wr(`A_FENA_BASE, 32'h5);
        wr(`A_FVAL_BASE, 32'h4);
        wr(`A_FENA_BASE + 8'h4, 32'h3);
        wr(`A_FVAL_BASE + 8'h4, 32'h1);
        wr(`A_FENA_BASE + 8'h9, 32'h1);
        wr(`A_FVAL_BASE + 8'h9, 32'h1);
        main_lvl <= 64'h0000_ffff_0000_00f3;
        out_image_main <= 64'hffff_0000_ffff_0000;
        refresh;
        check("raw in", 64'h0000_ffff_0000_00f3, in_image_main);
        check("raw out", 64'hffff_0000_ffff_0000, main_out_pins);
        wr(`A_CTRL, 32'h1);
        refresh;
        check("forced in", 64'h0000_ffff_0000_00f6, in_image_main);
        check("forced out", 64'hffff_0000_ffff_0001, main_out_pins);
        check("forced exp1", 16'h0001, exp1_out_pins);
        // only point 3 may move; bit 8 changes too but stays stale
        main_lvl <= 64'h0000_ffff_0000_01fb;
        direct_point <= 9'h003;
        tick(3);
        direct_refresh_instr <= 1;
        tick(1);
        direct_refresh_instr <= 0;
        tick(3);
        check("direct in", 64'h0000_ffff_0000_00fe, in_image_main);
        sys_rst <= 1;
        tick(1);
        sys_rst <= 0;
        tick(2);
        rd_chk("kept force", `A_FENA_BASE, 32'h5);
        program_download <= 1;
        tick(1);
        program_download <= 0;
        rd_chk("download clr", `A_FENA_BASE, 32'h0);
        wr(`A_FENA_BASE, 32'h5);
        backup_lost <= 1;
        tick(1);
        backup_lost <= 0;
        rd_chk("backup clr", `A_FENA_BASE, 32'h0);
        wr(`A_FENA_BASE, 32'h5);
        boot(1);
        check("flash on", 1, flash_operation);
        rd_chk("flash clr", `A_FENA_BASE, 32'h0);
        boot(0);
        wr(`A_WDT_MS, 32'h1);
        tick(20000);
        scan_end <= 1;
        tick(1);
        scan_end <= 0;
        tick(20000);
        scan_timer_restart_instr <= 1;
        tick(1);
        scan_timer_restart_instr <= 0;
        n = 0;
        while (program_run === 1'b1 && n < 60000) begin
            n++;
            tick(1);
        end
        check("wdt span", 1, n >= 49990 && n <= 50010);
        tick(2);
        check("outs off", 64'h0, main_out_pins);
        check("run lamp", 0, run_indicator);
        rd_chk("wdt code", `A_HIST_BASE + 8'h3, `ERR_WDT);
        rd_chk("yymm", `A_HIST_BASE, 32'h2405);
        rd_chk("mmss", `A_HIST_BASE + 8'h2, 32'h3045);
        boot(0);
        diag_fault <= 1;
        tick(3);
        check("diag halt", 0, program_run);
        check("diag lamp", 1, fault_indicator);
        diag_fault <= 0;
        rd_chk("diag code", `A_HIST_BASE + 8'h3, `ERR_DIAG);
        rd_chk("older code", `A_HIST_BASE + 8'h7, `ERR_WDT);
        test_done;
    end
endmodule // scan_supervisor_test
